// *** src/ocs_pkg.sv ***
// package: constants, types and helpers for the off-sequence/retry block
package ocs_pkg;
	// timebase: 10 us tick from 25 MHz
	localparam int              CLK_HZ      = 25_000_000;
	localparam int              TICK_US     = 10;
	localparam logic [7:0]      TICK_CYC_M1 = 8'(CLK_HZ / 1_000_000 * TICK_US - 1);
	// ramp step period and clamps
	localparam int              STEP_US     = 100;
	localparam logic [3:0]      STEP_TICKS  = 4'(STEP_US / TICK_US);
	localparam int              MIN_FALL_US = 250;
	localparam logic [13:0]     MIN_STEPS   = 14'((MIN_FALL_US + STEP_US - 1) / STEP_US);
	localparam int              MIN_DLY_US  = 270;
	localparam logic [27:0]     MIN_DLY_TK  = 28'(MIN_DLY_US / TICK_US);
	localparam logic [27:0]     HOLD_RES_MS = 28'h0000010;
	// command codes
	localparam logic [7:0]      CMD_OV_ACT  = 8'h41;
	localparam logic [7:0]      CMD_UV_ACT  = 8'h45;
	localparam logic [7:0]      CMD_VIN_ACT = 8'h56;
	localparam logic [7:0]      CMD_TON_ACT = 8'h63;
	localparam logic [7:0]      CMD_DLY     = 8'h64;
	localparam logic [7:0]      CMD_FALL    = 8'h65;
	localparam logic [7:0]      CMD_WARN    = 8'h66;
	localparam logic [7:0]      CMD_RETRY   = 8'hDB;
	localparam logic [7:0]      CMD_HOLD    = 8'hDC;
	// values after reset
	localparam logic [7:0]      RST_OUT_ACT = 8'hB8;
	localparam logic [7:0]      RST_VIN_ACT = 8'h80;
	localparam logic [15:0]     RST_DLY     = 16'h8000;
	localparam logic [15:0]     RST_FALL    = 16'hD200;
	localparam logic [15:0]     RST_WARN    = 16'hF258;
	localparam logic [15:0]     RST_RETRY   = 16'hFABC;
	localparam logic [15:0]     RST_HOLD    = 16'hFBE8;

	typedef enum logic [2:0] {
		ST_ON      = 3'h0,
		ST_DELAY   = 3'h1,
		ST_RAMP    = 3'h2,
		ST_DECAY   = 3'h3,
		ST_OFF     = 3'h4,
		ST_RETRY   = 3'h5,
		ST_LATCHED = 3'h6
	} ocs_state_type;

	typedef struct packed {
		logic [7:0]  ov_act;
		logic [7:0]  uv_act;
		logic [7:0]  vin_act;
		logic [7:0]  ton_act;
		logic [15:0] dly;
		logic [15:0] fall;
		logic [15:0] warn;
		logic [15:0] retry;
		logic [15:0] hold;
	} ocs_regs_type;

	typedef struct packed {
		ocs_state_type state;
		logic [27:0]   cnt;
		logic [3:0]    sub;
		logic [13:0]   step;
		logic [13:0]   den;
		logic [27:0]   wcnt;
		logic          warn;
		logic [27:0]   hcnt;
		logic          hold;
		logic          start;
		logic          hiz;
		logic          run_s1;
		logic          run_s2;
		logic          run_s3;
		logic          vab_s1;
		logic          vab_s2;
	} ocs_ch_type;

	// linear word (5-bit exponent, 11-bit mantissa) times mult, saturated
	function automatic logic [27:0] lin_cnt(input logic [15:0] w,
		input logic [6:0] mult);
		logic [44:0] p;
		logic [44:0] r;
		p = 45'(w[10] ? 10'h000 : w[9:0]) * 45'(mult);
		if (w[15])
			r = p >> (6'h20 - {1'b0, w[15:11]});
		else
			r = p << w[14:11];
		lin_cnt = (|r[44:28]) ? 28'hFFFFFFF : r[27:0];
	endfunction

	function automatic logic act_shuts(input logic [7:0] a);
		act_shuts = (a[7:6] == 2'h2) || (a[7:6] == 2'h1);
	endfunction

	function automatic logic act_retries(input logic [7:0] a);
		act_retries = (a[5:3] == 3'h7);
	endfunction
endpackage

// *** src/ocs_off_seq.sv ***
// two-channel turn-off sequencer, restart hold and fault retry timing
//
// Functional notes
// - after stop, wait programmed off delay (0..83 s) before falling
// - fault shutdown skips the off delay entirely
// - zero off delay gives about 270 us; tolerance 50 us
// - after delay ramp reference to zero over fall time, then hi-z
// - fall time below 0.25 ms clamps to 0.25 ms (code rounds up to 3 steps, 0.3 ms); max 1.3 s
// - ramp is fall time / 0.1 ms discrete steps
// - discontinuous mode kept; no sinking during fall
// - time output above 12.5% after ramp; warn past limit
// - warn limit zero disables warning; else 120 ms..524 s
// - on run falling edge hold run low for restart time, then start
// - restart time 136 ms..65.52 s in 16 ms steps
// - decay option bit keeps output off until below 12.5%
// - one retry interval for all retrying faults, starts at detection
// - retry interval 120 ms..83.88 s, 10 us resolution
// - retry waits longer of interval and decay; option drops decay
// - input overvoltage action byte per channel, reset 0x80
// - input overvoltage sets other, input, input-ov flags and alert
// - timing settings are two-byte linear words
// - fault actions are single bytes
// - output ov, uv, turn-on-timeout actions per channel, reset 0xB8
// - reset delay 0x8000, fall 0xD200, warn 0xF258
// - retry field 111 restarts after each retry interval
// - action 0x80 shuts down without retry
`timescale 1ns/100ps
`default_nettype none
module ocs_off_seq
(
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rstn,
	// command register port
	input  wire logic              i_cmd_wr,
	input  wire logic              i_cmd_rd,
	input  wire logic              i_cmd_page,
	input  wire logic [7:0]        i_cmd_code,
	input  wire logic [15:0]       i_cmd_wdata,
	output logic [15:0]            o_cmd_rdata,
	output logic                   o_cmd_rvalid,
	output logic                   o_cmd_unsup,
	// per channel control and pins
	input  wire logic [1:0]        i_run,
	input  wire logic [1:0]        i_op_on,
	input  wire logic [1:0]        i_vout_above,
	input  wire logic [1:0]        i_decay_opt,
	input  wire logic [1:0]        i_fault_ov,
	input  wire logic [1:0]        i_fault_uv,
	input  wire logic [1:0]        i_fault_ton,
	output logic [1:0]             o_run_out,
	output logic [1:0]             o_run_oe,
	output logic [1:0]             o_pwm_hiz,
	output logic [1:0]             o_start,
	output logic [1:0]             o_off_warn,
	output logic [1:0][13:0]       o_ramp_num,
	output logic [1:0][13:0]       o_ramp_den,
	// input overvoltage and status
	input  wire logic              i_vin_ov,
	input  wire logic              i_clear_faults,
	input  wire logic              i_alert_mask,
	output logic                   o_other_fault_flag,
	output logic                   o_input_flag,
	output logic                   o_vin_ov_flag,
	output logic                   o_alert_out,
	output logic                   o_alert_oe
);
	typedef struct packed {
		ocs_pkg::ocs_ch_type   [1:0] ch;
		ocs_pkg::ocs_regs_type [1:0] regs;
		logic [7:0]                  tdiv;
		logic                        tick;
		logic                        vin_s1;
		logic                        vin_s2;
		logic                        vin_s3;
		logic                        other;
		logic                        inp;
		logic                        vinov;
		logic                        alert;
		logic [15:0]                 rdata;
		logic                        rvalid;
		logic                        unsup;
	} ocs_st_type;

	localparam ocs_pkg::ocs_regs_type RST_REGS = '{
		ov_act:  ocs_pkg::RST_OUT_ACT,
		uv_act:  ocs_pkg::RST_OUT_ACT,
		vin_act: ocs_pkg::RST_VIN_ACT,
		ton_act: ocs_pkg::RST_OUT_ACT,
		dly:     ocs_pkg::RST_DLY,
		fall:    ocs_pkg::RST_FALL,
		warn:    ocs_pkg::RST_WARN,
		retry:   ocs_pkg::RST_RETRY,
		hold:    ocs_pkg::RST_HOLD
	};

	ocs_st_type st_ff;
	ocs_st_type nxt_st;

	// next-state logic for timebase, status, registers and both channels
	always_comb
	begin
		ocs_pkg::ocs_ch_type   c;
		ocs_pkg::ocs_regs_type r;
		logic                  vin_evt;
		logic                  on_cmd;
		logic                  shut;
		logic                  rty;
		logic                  vab;
		logic                  run_fall;
		logic [27:0]           t_dly;
		logic [27:0]           t_ms;
		logic [27:0]           t_hold;
		logic [13:0]           steps;
		nxt_st   = st_ff;
		c        = '0;
		r        = '0;
		vin_evt  = 1'b0;
		on_cmd   = 1'b0;
		shut     = 1'b0;
		rty      = 1'b0;
		vab      = 1'b0;
		run_fall = 1'b0;
		t_dly    = '0;
		t_ms     = '0;
		t_hold   = '0;
		steps    = '0;

		// shared 10 us tick for every timer
		nxt_st.tick = 1'b0;
		if (st_ff.tdiv == ocs_pkg::TICK_CYC_M1)
		begin
			nxt_st.tdiv = 8'h00;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.tdiv = st_ff.tdiv + 8'h01;

		// input overvoltage pin: sync, then rising edge from stage two
		nxt_st.vin_s1 = i_vin_ov;
		nxt_st.vin_s2 = st_ff.vin_s1;
		nxt_st.vin_s3 = st_ff.vin_s2;
		vin_evt = st_ff.vin_s2 & ~st_ff.vin_s3;

		// sticky flags; a new event wins over a clear in the same cycle
		if (i_clear_faults)
		begin
			nxt_st.other = 1'b0;
			nxt_st.inp   = 1'b0;
			nxt_st.vinov = 1'b0;
		end
		if (vin_evt)
		begin
			nxt_st.other = 1'b1;
			nxt_st.inp   = 1'b1;
			nxt_st.vinov = 1'b1;
		end
		nxt_st.alert = nxt_st.vinov & ~i_alert_mask;

		// command port: byte actions, word timing settings, paged
		nxt_st.rvalid = i_cmd_rd;
		nxt_st.unsup  = 1'b0;
		r = st_ff.regs[i_cmd_page];
		nxt_st.rdata = 16'h0000;
		case (i_cmd_code)
			ocs_pkg::CMD_OV_ACT:  nxt_st.rdata = {8'h00, r.ov_act};
			ocs_pkg::CMD_UV_ACT:  nxt_st.rdata = {8'h00, r.uv_act};
			ocs_pkg::CMD_VIN_ACT: nxt_st.rdata = {8'h00, r.vin_act};
			ocs_pkg::CMD_TON_ACT: nxt_st.rdata = {8'h00, r.ton_act};
			ocs_pkg::CMD_DLY:     nxt_st.rdata = r.dly;
			ocs_pkg::CMD_FALL:    nxt_st.rdata = r.fall;
			ocs_pkg::CMD_WARN:    nxt_st.rdata = r.warn;
			ocs_pkg::CMD_RETRY:   nxt_st.rdata = r.retry;
			ocs_pkg::CMD_HOLD:    nxt_st.rdata = r.hold;
			default:              nxt_st.unsup = i_cmd_rd | i_cmd_wr;
		endcase
		if (i_cmd_wr)
		begin
			case (i_cmd_code)
				ocs_pkg::CMD_OV_ACT:  r.ov_act  = i_cmd_wdata[7:0];
				ocs_pkg::CMD_UV_ACT:  r.uv_act  = i_cmd_wdata[7:0];
				ocs_pkg::CMD_VIN_ACT: r.vin_act = i_cmd_wdata[7:0];
				ocs_pkg::CMD_TON_ACT: r.ton_act = i_cmd_wdata[7:0];
				ocs_pkg::CMD_DLY:     r.dly     = i_cmd_wdata;
				ocs_pkg::CMD_FALL:    r.fall    = i_cmd_wdata;
				ocs_pkg::CMD_WARN:    r.warn    = i_cmd_wdata;
				ocs_pkg::CMD_RETRY:   r.retry   = i_cmd_wdata;
				ocs_pkg::CMD_HOLD:    r.hold    = i_cmd_wdata;
				default:              r = r;
			endcase
			nxt_st.regs[i_cmd_page] = r;
		end

		// per-channel sequencers, each independent
		for (int k = 0; k < 2; k++)
		begin
			c = st_ff.ch[k];
			r = st_ff.regs[k];
			c.start = 1'b0;

			// run and comparator pins through two flops
			c.run_s1 = i_run[k];
			c.run_s2 = st_ff.ch[k].run_s1;
			c.run_s3 = st_ff.ch[k].run_s2;
			c.vab_s1 = i_vout_above[k];
			c.vab_s2 = st_ff.ch[k].vab_s1;
			vab      = st_ff.ch[k].vab_s2;
			run_fall = st_ff.ch[k].run_s3 & ~st_ff.ch[k].run_s2;

			// settings in 10 us ticks or 0.1 ms steps
			t_dly = ocs_pkg::lin_cnt(r.dly, 7'd100);
			if (t_dly < ocs_pkg::MIN_DLY_TK)
				t_dly = ocs_pkg::MIN_DLY_TK;
			steps = 14'(ocs_pkg::lin_cnt(r.fall, 7'd10));
			if (steps < ocs_pkg::MIN_STEPS)
				steps = ocs_pkg::MIN_STEPS;
			// hold rounds down to whole 16 ms increments
			t_ms   = ocs_pkg::lin_cnt(r.hold, 7'd1);
			t_hold = 28'((t_ms / ocs_pkg::HOLD_RES_MS)
				* ocs_pkg::HOLD_RES_MS * 28'd100);

			// restart hold: pull run low, then optionally wait for decay
			if (run_fall && !st_ff.ch[k].hold)
			begin
				c.hold = 1'b1;
				c.hcnt = t_hold;
			end
			else if (st_ff.ch[k].hold && st_ff.tick)
			begin
				if (st_ff.ch[k].hcnt != 28'h0)
					c.hcnt = st_ff.ch[k].hcnt - 28'h1;
				else if (!(i_decay_opt[k] && vab))
					c.hold = 1'b0;
			end
			on_cmd = st_ff.ch[k].run_s2 & i_op_on[k] & ~st_ff.ch[k].hold;

			// fault response from each action byte
			shut = 1'b0;
			rty  = 1'b1;
			if (i_fault_ov[k] && ocs_pkg::act_shuts(r.ov_act))
			begin
				shut = 1'b1;
				rty  = rty & ocs_pkg::act_retries(r.ov_act);
			end
			if (i_fault_uv[k] && ocs_pkg::act_shuts(r.uv_act))
			begin
				shut = 1'b1;
				rty  = rty & ocs_pkg::act_retries(r.uv_act);
			end
			if (i_fault_ton[k] && ocs_pkg::act_shuts(r.ton_act))
			begin
				shut = 1'b1;
				rty  = rty & ocs_pkg::act_retries(r.ton_act);
			end
			if (vin_evt && ocs_pkg::act_shuts(r.vin_act))
			begin
				shut = 1'b1;
				rty  = rty & ocs_pkg::act_retries(r.vin_act);
			end

			case (st_ff.ch[k].state)
				ocs_pkg::ST_ON:
				begin
					c.step = steps;
					c.den  = steps;
					c.hiz  = 1'b0;
					if (!on_cmd)
					begin
						c.state = ocs_pkg::ST_DELAY;
						c.cnt   = t_dly;
					end
				end
				ocs_pkg::ST_DELAY:
					if (st_ff.tick)
					begin
						if (st_ff.ch[k].cnt > 28'h1)
							c.cnt = st_ff.ch[k].cnt - 28'h1;
						else
						begin
							c.state = ocs_pkg::ST_RAMP;
							c.sub   = ocs_pkg::STEP_TICKS;
						end
					end
				ocs_pkg::ST_RAMP:
					// mode is left alone; light loads may lag the ramp
					if (st_ff.tick)
					begin
						if (st_ff.ch[k].sub > 4'h1)
							c.sub = st_ff.ch[k].sub - 4'h1;
						else if (st_ff.ch[k].step > 14'h1)
						begin
							c.step = st_ff.ch[k].step - 14'h1;
							c.sub  = ocs_pkg::STEP_TICKS;
						end
						else
						begin
							c.step  = 14'h0;
							c.hiz   = 1'b1;
							c.state = ocs_pkg::ST_DECAY;
							c.wcnt  = 28'h0;
						end
					end
				ocs_pkg::ST_DECAY:
					if (!vab)
						c.state = ocs_pkg::ST_OFF;
					else if (st_ff.tick)
					begin
						if (st_ff.ch[k].wcnt != 28'hFFFFFFF)
							c.wcnt = st_ff.ch[k].wcnt + 28'h1;
						// a zero limit in any encoding disables
						if (ocs_pkg::lin_cnt(r.warn, 7'd100) != 28'h0
							&& (st_ff.ch[k].wcnt
							>= ocs_pkg::lin_cnt(r.warn, 7'd100)))
							c.warn = 1'b1;
					end
				ocs_pkg::ST_OFF:
					if (on_cmd)
					begin
						c.state = ocs_pkg::ST_ON;
						c.start = 1'b1;
						c.warn  = 1'b0;
					end
				ocs_pkg::ST_RETRY:
					if (st_ff.tick)
					begin
						if (st_ff.ch[k].cnt != 28'h0)
							c.cnt = st_ff.ch[k].cnt - 28'h1;
						else if (i_decay_opt[k] || !vab)
						begin
							c.state = on_cmd ? ocs_pkg::ST_ON : ocs_pkg::ST_OFF;
							c.start = on_cmd;
						end
					end
				ocs_pkg::ST_LATCHED:
					// stays down until commanded off, then may start again
					if (!on_cmd)
						c.state = ocs_pkg::ST_OFF;
				default:
					c.state = ocs_pkg::ST_OFF;
			endcase

			// fault shutdown bypasses the off delay and the ramp
			if (shut && st_ff.ch[k].state != ocs_pkg::ST_LATCHED)
			begin
				c.hiz   = 1'b1;
				c.step  = 14'h0;
				c.state = rty ? ocs_pkg::ST_RETRY : ocs_pkg::ST_LATCHED;
				c.cnt   = ocs_pkg::lin_cnt(r.retry, 7'd100);
				c.start = 1'b0;
			end
			nxt_st.ch[k] = c;
		end
	end

	// single state register
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_ff      <= '0;
			st_ff.regs <= {RST_REGS, RST_REGS};
			// run syncs start at the idle-high level: no false stop
			st_ff.ch[0].run_s1 <= 1'b1;
			st_ff.ch[0].run_s2 <= 1'b1;
			st_ff.ch[0].run_s3 <= 1'b1;
			st_ff.ch[1].run_s1 <= 1'b1;
			st_ff.ch[1].run_s2 <= 1'b1;
			st_ff.ch[1].run_s3 <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// outputs straight from the state register; o_run_out and o_alert_out tied low
	assign o_cmd_rdata        = st_ff.rdata;
	assign o_cmd_rvalid       = st_ff.rvalid;
	assign o_cmd_unsup        = st_ff.unsup;
	assign o_run_out          = 2'h0;
	assign o_run_oe           = {st_ff.ch[1].hold, st_ff.ch[0].hold};
	assign o_pwm_hiz          = {st_ff.ch[1].hiz, st_ff.ch[0].hiz};
	assign o_start            = {st_ff.ch[1].start, st_ff.ch[0].start};
	assign o_off_warn         = {st_ff.ch[1].warn, st_ff.ch[0].warn};
	assign o_ramp_num         = {st_ff.ch[1].step, st_ff.ch[0].step};
	assign o_ramp_den         = {st_ff.ch[1].den, st_ff.ch[0].den};
	assign o_other_fault_flag = st_ff.other;
	assign o_input_flag       = st_ff.inp;
	assign o_vin_ov_flag      = st_ff.vinov;
	assign o_alert_out        = 1'b0;
	assign o_alert_oe         = st_ff.alert;
endmodule // ocs_off_seq
`default_nettype wire

// *** bench/ocs_off_seq_properties.sv ***
// checker: port-level properties of the off-sequence block
`timescale 1ns/100ps
`default_nettype none
module ocs_off_seq_properties
(
	// clock and reset
	input wire logic             i_sys_clk,
	input wire logic             i_rstn,
	// watched inputs
	input wire logic             i_cmd_rd,
	input wire logic [7:0]       i_cmd_code,
	input wire logic [1:0]       i_run,
	input wire logic             i_alert_mask,
	// watched outputs
	input wire logic             o_cmd_rvalid,
	input wire logic             o_cmd_unsup,
	input wire logic [1:0]       o_pwm_hiz,
	input wire logic [1:0]       o_start,
	input wire logic [1:0]       o_off_warn,
	input wire logic [1:0][13:0] o_ramp_num,
	input wire logic [1:0]       o_run_oe,
	input wire logic             o_other_fault_flag,
	input wire logic             o_input_flag,
	input wire logic             o_vin_ov_flag,
	input wire logic             o_alert_oe
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	logic known;
	// codes the block answers; anything else is refused
	assign known = i_cmd_code inside {8'h41, 8'h45, 8'h56, 8'h63, 8'h64,
		8'h65, 8'h66, 8'hDB, 8'hDC};

	property p_rd_ans;
		i_cmd_rd && known |=> o_cmd_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_unsup;
		i_cmd_rd && !known |=> o_cmd_unsup;
	endproperty
	a_unsup: assert property (p_unsup) else $error("unknown code taken");
	property p_step;
		o_ramp_num[0] != 14'h0 && o_ramp_num[0] < $past(o_ramp_num[0])
			|=> $stable(o_ramp_num[0])[*8];
	endproperty
	a_step: assert property (p_step) else $error("ramp step too short");
	property p_ramp_end;
		o_ramp_num[0] == 14'h0 && $past(o_ramp_num[0]) != 14'h0
			|-> ##[0:2] o_pwm_hiz[0];
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("no hiz at zero");
	property p_start;
		o_start[0] |=> !o_start[0] && !o_pwm_hiz[0];
	endproperty
	a_start: assert property (p_start) else $error("start pulse wrong");
	property p_hiz_fall;
		$fell(o_pwm_hiz[1]) |-> o_start[1] || $past(o_start[1]);
	endproperty
	a_hiz_fall: assert property (p_hiz_fall) else $error("hiz left early");
	property p_warn;
		$rose(o_off_warn[0]) |-> o_pwm_hiz[0];
	endproperty
	a_warn: assert property (p_warn) else $error("warning before ramp end");
	property p_flags;
		o_other_fault_flag == o_vin_ov_flag && o_input_flag == o_vin_ov_flag;
	endproperty
	a_flags: assert property (p_flags) else $error("status flags differ");
	property p_alert;
		o_vin_ov_flag && !$past(i_alert_mask) |-> o_alert_oe;
	endproperty
	a_alert: assert property (p_alert) else $error("alert not raised");
	property p_mask;
		i_alert_mask |=> !o_alert_oe;
	endproperty
	a_mask: assert property (p_mask) else $error("masked alert raised");
	property p_hold;
		$fell(i_run[0]) |-> ##[1:5] o_run_oe[0];
	endproperty
	a_hold: assert property (p_hold) else $error("run not held low");
endmodule // ocs_off_seq_properties

bind ocs_off_seq ocs_off_seq_properties ocs_off_seq_properties_i (
	.i_sys_clk, .i_rstn, .i_cmd_rd, .i_cmd_code, .i_run, .i_alert_mask,
	.o_cmd_rvalid, .o_cmd_unsup, .o_pwm_hiz, .o_start, .o_off_warn,
	.o_ramp_num, .o_run_oe, .o_other_fault_flag, .o_input_flag,
	.o_vin_ov_flag, .o_alert_oe);
`default_nettype wire

// *** bench/ocs_far_end.sv ***
// far-side model: output decay comparator and open-drain run line
`timescale 1ns/100ps
`default_nettype none
module ocs_far_end
#(
	parameter int DECAY_CYC = 8000
)
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// device pins seen from outside
	input  wire logic [1:0] i_hiz,
	input  wire logic [1:0] i_run_oe,
	input  wire logic [1:0] i_host_run,
	output logic [1:0]      o_vout_above,
	output logic [1:0]      o_run
);
	int cnt_ff [2];
	// run line has a pull-up; either party may pull it low
	assign o_run = i_host_run & ~i_run_oe;
	// slow decay so it outlasts a short retry interval
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		for (int c = 0; c < 2; c++)
		begin
			if (!i_rstn)
				cnt_ff[c] <= 0;
			else if (!i_hiz[c])
				cnt_ff[c] <= 0;
			else if (cnt_ff[c] < DECAY_CYC)
				cnt_ff[c] <= cnt_ff[c] + 1;
		end
	end
	// above 12.5 % until the decay has run out
	always_comb
		for (int c = 0; c < 2; c++)
			o_vout_above[c] = (cnt_ff[c] < DECAY_CYC);
endmodule // ocs_far_end
`default_nettype wire

// *** bench/output_off_sequence_retry_timer_tb.sv ***
// testbench: off sequence, warning, retry, flags and restart hold
`timescale 1ns/100ps
`default_nettype none
module output_off_sequence_retry_timer_tb;
	logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_cmd_wr = 1'b0, i_cmd_rd = 1'b0;
	logic i_cmd_page = 1'b0, i_vin_ov = 1'b0, i_clear_faults = 1'b0;
	logic i_alert_mask = 1'b0;
	logic [7:0] i_cmd_code = 8'h00;
	logic [15:0] i_cmd_wdata = 16'h0000, o_cmd_rdata;
	logic [1:0] i_op_on = 2'h3, i_decay_opt = 2'h0, host_run = 2'h3;
	logic [1:0] i_fault_ov = 2'h0, i_fault_uv = 2'h0, i_fault_ton = 2'h0;
	wire logic [1:0] i_run, i_vout_above;
	logic o_cmd_rvalid, o_cmd_unsup, o_other_fault_flag, o_input_flag;
	logic o_vin_ov_flag, o_alert_out, o_alert_oe;
	logic [1:0] o_run_out, o_run_oe, o_pwm_hiz, o_start, o_off_warn;
	logic [1:0][13:0] o_ramp_num, o_ramp_den;
	int fails = 0, check_count = 0, n;

	// 25 MHz system clock
	always #20 i_sys_clk = ~i_sys_clk;

	ocs_off_seq ocs_off_seq_i (.i_sys_clk, .i_rstn, .i_cmd_wr, .i_cmd_rd,
		.i_cmd_page, .i_cmd_code, .i_cmd_wdata, .o_cmd_rdata, .o_cmd_rvalid,
		.o_cmd_unsup, .i_run, .i_op_on, .i_vout_above, .i_decay_opt,
		.i_fault_ov, .i_fault_uv, .i_fault_ton, .o_run_out, .o_run_oe,
		.o_pwm_hiz, .o_start, .o_off_warn, .o_ramp_num, .o_ramp_den,
		.i_vin_ov, .i_clear_faults, .i_alert_mask, .o_other_fault_flag,
		.o_input_flag, .o_vin_ov_flag, .o_alert_out, .o_alert_oe);
	ocs_far_end #(.DECAY_CYC(8000)) ocs_far_end_i (.i_clk(i_sys_clk),
		.i_rstn(i_rstn), .i_hiz(o_pwm_hiz), .i_run_oe(o_run_oe),
		.i_host_run(host_run), .o_vout_above(i_vout_above), .o_run(i_run));

	task automatic summarize;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge i_sys_clk);
	endtask
	// command port cycles, one strobe cycle each
	task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
		tick(1);
		i_cmd_page = p;
		i_cmd_code = c;
		i_cmd_wdata = d;
		i_cmd_wr = 1'b1;
		tick(1);
		i_cmd_wr = 1'b0;
	endtask
	task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e,
		input logic un);
		tick(1);
		i_cmd_page = p;
		i_cmd_code = c;
		i_cmd_rd = 1'b1;
		tick(1);
		i_cmd_rd = 1'b0;
		// answer stands for this one cycle only
		chk(16'(o_cmd_rvalid), 16'h1);
		chk(16'(o_cmd_unsup), 16'(un));
		if (!un)
			chk(o_cmd_rdata, e);
	endtask
	// bounded wait for a restart pulse
	task automatic wait_start(input int ch, input int lim);
		n = 0;
		while (o_start[ch] !== 1'b1 && n < lim)
		begin
			tick(1);
			n++;
		end
		chk(16'(n < lim), 16'h1);
	endtask
	// reset values on both pages, per-page storage, refused codes
	task automatic t_regs;
		logic [7:0] c [9] = '{8'h41, 8'h45, 8'h56, 8'h63, 8'h64, 8'h65,
			8'h66, 8'hDB, 8'hDC};
		logic [15:0] e [9] = '{16'h00B8, 16'h00B8, 16'h0080, 16'h00B8,
			16'h8000, 16'hD200, 16'hF258, 16'hFABC, 16'hFBE8};
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 9; i++)
				rd(1'(p), c[i], e[i], 1'b0);
		wr(1'b1, 8'h63, 16'h0078);
		rd(1'b0, 8'h63, 16'h00B8, 1'b0);
		rd(1'b1, 8'h63, 16'h0078, 1'b0);
		wr(1'b0, 8'hDB, 16'h1234);
		rd(1'b0, 8'hDB, 16'h1234, 1'b0);
		rd(1'b0, 8'h42, 16'h0000, 1'b1);
	endtask
	// stop on channel 0: delay, clamped or plain ramp, then restart
	task automatic t_off(input logic [15:0] dw, input int dtk,
		input logic [15:0] fw, input int st);
		int lo;
		int hi;
		lo = (dtk + 10 * st - 1) * 250;
		hi = (dtk + 10 * st + 2) * 250;
		wr(1'b0, 8'h64, dw);
		wr(1'b0, 8'h65, fw);
		i_op_on[0] = 1'b0;
		n = 0;
		while (o_pwm_hiz[0] !== 1'b1 && n < hi)
		begin
			tick(1);
			n++;
		end
		chk(16'(n >= lo && n < hi), 16'h1);
		chk(16'(o_ramp_num[0]), 16'h0);
		chk(16'(o_ramp_den[0]), 16'(st));
		i_op_on[0] = 1'b1;
		wait_start(0, 12000);
		tick(2);
		chk(16'(o_pwm_hiz[0]), 16'h0);
	endtask
	// decay warning on channel 0, limit zero on channel 1
	task automatic t_warn;
		wr(1'b0, 8'h64, 16'h8000);
		wr(1'b0, 8'h66, 16'hF001);
		wr(1'b1, 8'h66, 16'h8000);
		wr(1'b1, 8'h65, 16'hE801);
		i_op_on = 2'h0;
		n = 0;
		while (o_pwm_hiz !== 2'h3 && n < 16000)
		begin
			tick(1);
			n++;
		end
		tick(7000);
		chk(16'(o_off_warn), 16'h0001);
		i_op_on = 2'h3;
		wait_start(0, 4000);
		tick(300);
		chk(16'(o_off_warn), 16'h0000);
	endtask
	// retry paced by the interval when decay is ignored; 0x80 latches
	task automatic t_fault;
		i_decay_opt[1] = 1'b1;
		wr(1'b1, 8'hDB, 16'hE801);
		i_fault_ov[1] = 1'b1;
		tick(1);
		i_fault_ov[1] = 1'b0;
		tick(3);
		chk(16'(o_pwm_hiz[1]), 16'h1);
		wait_start(1, 6000);
		chk(16'(n >= 2500 && n < 3500), 16'h1);
		wr(1'b1, 8'h45, 16'h0080);
		i_fault_uv[1] = 1'b1;
		tick(1);
		i_fault_uv[1] = 1'b0;
		tick(3);
		chk(16'(o_pwm_hiz[1]), 16'h1);
		n = 0;
		repeat (4000)
		begin
			tick(1);
			if (o_start[1] === 1'b1)
				n++;
		end
		chk(16'(n), 16'h0);
	endtask
	// input overvoltage flags, alert masking and clearing
	task automatic t_vin;
		i_alert_mask = 1'b1;
		i_vin_ov = 1'b1;
		tick(6);
		i_vin_ov = 1'b0;
		chk(16'({o_other_fault_flag, o_input_flag, o_vin_ov_flag,
			o_alert_oe}), 16'h000E);
		i_alert_mask = 1'b0;
		tick(2);
		chk(16'(o_alert_oe), 16'h1);
		i_clear_faults = 1'b1;
		tick(1);
		i_clear_faults = 1'b0;
		tick(2);
		chk(16'({o_other_fault_flag, o_input_flag, o_vin_ov_flag,
			o_alert_oe}), 16'h0000);
	endtask
	// run pin pulled low by the device after an outside falling edge
	task automatic t_hold;
		host_run[0] = 1'b0;
		tick(8);
		host_run[0] = 1'b1;
		chk(16'(o_run_oe[0]), 16'h1);
		tick(1000);
		chk(16'({o_run_oe[0], i_run[0]}), 16'h0002);
		chk(16'({o_run_out, o_alert_out}), 16'h0000);
	endtask

	// main sequence
	initial
	begin
		repeat (3) @(posedge i_sys_clk);
		tick(1);
		i_rstn = 1'b1;
		t_regs;
		t_off(16'h8000, 27, 16'hE801, 3);
		t_warn;
		t_off(16'h0001, 100, 16'hF801, 5);
		t_fault;
		t_vin;
		t_hold;
		summarize;
	end
	// watchdog well past the expected run length
	initial
	begin
		#(40 * 120000);
		fails++;
		summarize;
	end
endmodule // output_off_sequence_retry_timer_tb
`default_nettype wire
